// file: rtl/dfs_device.sv
// What this block does
// [RULE_01] Host enables deviation only while loop locked
// [RULE_02] Hold 38-bit deviation step word
// [RULE_03] Add or subtract step from feedback numerator
// [RULE_04] Update write 0 raises, 1 lowers
// [RULE_05] Trigger pin rising edge applies one step
// [RULE_06] Direction pin 0 positive, 1 negative
// [RULE_07] Trigger high pulse longer than 100 ns
// [RULE_08] Pin step events below 5 MHz
// [RULE_09] Disable restores original programmed numerator
// [RULE_10] Absolute write of full 40-bit numerator
// [RULE_11] Denominator zero means two to forty
// [RULE_12] Digital steering closed loop, analog otherwise
// [RULE_13] Host sets loop enable and denominator mode
// [RULE_14] Analog numerator equals base plus offset
// [RULE_15] Effective analog numerator readable back
// [RULE_16] History mode feeds offset at step rate
// [RULE_17] New offset drops pending steps immediately
// [RULE_18] Completion flag once offset fully applied
// [RULE_19] Software updates accepted regardless of pins
// [RULE_20] Synchronise pins, one update per edge
//
// The implementer's own choices: the AXI4-Lite register port and the register addresses.
module dfs_device
  import dfs_pkg::*;
(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  dfs_if.dev                        port,
  input  wire logic                 in_holdover,
  output logic      [DFS_NUM_W-1:0] dig_num_eff,
  output logic      [DFS_NUM_W:0]   dig_den_eff,
  output logic      [DFS_NUM_W-1:0] ana_num_eff,
  output logic                      ana_done
);
  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic [DFS_CTRL_W-1:0] ctrl_q;
  logic [DFS_STEP_W-1:0] step_q;
  logic [DFS_NUM_W-1:0]  fb_num_q;
  logic [DFS_NUM_W-1:0]  fb_den_q;
  logic [DFS_NUM_W-1:0]  hold_ofs_q;
  logic [DFS_NUM_W-1:0]  ana_base_q;
  logic [DFS_NUM_W-1:0]  step_sz_q;
  logic [DFS_PER_W-1:0]  step_per_q;
  logic [DFS_PER_W-1:0]  tick_cnt_q;
  logic [DFS_NUM_W-1:0]  applied_q;
  logic [DFS_NUM_W:0]    remain_q;
  logic [DFS_NUM_W-1:0]  rdata_q;
  logic                  rvalid_q;

  wire wr_any  = port.wr_en;
  wire wr_ctrl = wr_any && port.addr == DFS_R_CTRL;
  wire wr_step = wr_any && port.addr == DFS_R_DEV_STEP;
  wire wr_num  = wr_any && port.addr == DFS_R_FB_NUM;
  wire wr_den  = wr_any && port.addr == DFS_R_FB_DEN;
  wire wr_upd  = wr_any && port.addr == DFS_R_UPDATE;
  wire wr_ofs  = wr_any && port.addr == DFS_R_HOLD_OFS;
  wire wr_base = wr_any && port.addr == DFS_R_ANA_BASE;
  wire wr_ssz  = wr_any && port.addr == DFS_R_STEP_SZ;
  wire wr_sper = wr_any && port.addr == DFS_R_STEP_PER;
  wire wr_stat = wr_any && port.addr == DFS_R_STATUS;

  wire dev_en    = ctrl_q[DFS_C_DEV_EN];
  wire hist_en   = ctrl_q[DFS_C_HIST_EN];
  wire pin_en    = ctrl_q[DFS_C_PIN_EN];
  wire closed    = ctrl_q[DFS_C_DPLL_EN] && !in_holdover;   // [RULE_12]
  // History-mode analog stepping only runs once the host has set up the fractional
  // 40-bit denominator; absolute offset and base writes still change the numerator.
  wire ana_on    = !closed && ctrl_q[DFS_C_LOOP_EN]
                   && ctrl_q[DFS_C_DEN_MODE];               // [RULE_12]

  // ----------------------------------------------------------------
  // Pin capture
  // ----------------------------------------------------------------
  logic [1:0] pin_lvl;
  logic [1:0] pin_rise;

  dfs_pin_sync #(.W(2)) u_sync (                            // [RULE_20]
    .core_clk (core_clk),
    .rst      (rst),
    .pin      ({port.step_dir, port.step_trig}),
    .level    (pin_lvl),
    .rise     (pin_rise)
  );

  // ----------------------------------------------------------------
  // Digital steering
  // ----------------------------------------------------------------
  // Both sources may fire in one cycle; their steps are summed so
  // neither is lost.
  wire [DFS_NUM_W-1:0] step_ext = {2'b00, step_q};          // [RULE_02]
  wire                 sw_hit   = wr_upd;                   // [RULE_19]
  wire                 pin_hit  = pin_en && pin_rise[0];    // [RULE_05]
  wire [DFS_NUM_W-1:0] sw_term  = !sw_hit ? '0 :
    (port.wdata[0] ? -step_ext : step_ext);                 // [RULE_04]
  wire [DFS_NUM_W-1:0] pin_term = !pin_hit ? '0 :
    (pin_lvl[1] ? -step_ext : step_ext);                    // [RULE_06]
  wire [DFS_NUM_W-1:0] dig_next = dig_num_eff + sw_term + pin_term;

  // ----------------------------------------------------------------
  // Analog stepping
  // ----------------------------------------------------------------
  wire                 rem_neg = remain_q[DFS_NUM_W];
  wire [DFS_NUM_W:0]   rem_mag = rem_neg ? -remain_q : remain_q;
  wire [DFS_NUM_W:0]   sz_ext  = {1'b0, step_sz_q};
  wire [DFS_NUM_W:0]   chunk   = (rem_mag > sz_ext) ? sz_ext : rem_mag;
  wire [DFS_NUM_W:0]   chunk_s = rem_neg ? -chunk : chunk;
  wire                 tick    = hist_en && ana_on && remain_q != '0
                                 && tick_cnt_q >= step_per_q; // [RULE_16]
  wire                 finish  = tick && !wr_ofs
                                 && chunk == rem_mag;       // [RULE_18]
  wire                 abs_set = !hist_en && wr_ofs;
  wire [DFS_NUM_W:0]   ofs_ext = {port.wdata[DFS_NUM_W-1], port.wdata};

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ctrl_q     <= DFS_CTRL_RST;
      step_q     <= '0;
      fb_num_q   <= '0;
      fb_den_q   <= '0;
      hold_ofs_q <= '0;
      ana_base_q <= '0;
      step_sz_q  <= '0;
      step_per_q <= '0;
    end else begin
      if (wr_ctrl) ctrl_q     <= port.wdata[DFS_CTRL_W-1:0];
      if (wr_step) step_q     <= port.wdata[DFS_STEP_W-1:0];  // [RULE_02]
      if (wr_num)  fb_num_q   <= port.wdata;                  // [RULE_10]
      if (wr_den)  fb_den_q   <= port.wdata;
      if (wr_ofs)  hold_ofs_q <= port.wdata;
      if (wr_base) ana_base_q <= port.wdata;
      if (wr_ssz)  step_sz_q  <= port.wdata;
      if (wr_sper) step_per_q <= port.wdata[DFS_PER_W-1:0];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dig_num_eff <= '0;
    end else if (wr_num) begin
      dig_num_eff <= port.wdata;                            // [RULE_10]
    end else if (!dev_en) begin
      dig_num_eff <= fb_num_q;                              // [RULE_09]
    end else if (closed) begin
      dig_num_eff <= dig_next;                              // [RULE_03]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      dig_den_eff <= '0;
    end else begin
      dig_den_eff <= (fb_den_q == '0) ? {1'b1, {DFS_NUM_W{1'b0}}}
                                      : {1'b0, fb_den_q};   // [RULE_11]
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      applied_q  <= '0;
      remain_q   <= '0;
      tick_cnt_q <= '0;
    end else if (!hist_en) begin
      applied_q  <= hold_ofs_q;                             // [RULE_14]
      remain_q   <= '0;
      tick_cnt_q <= '0;
    end else if (wr_ofs) begin
      remain_q   <= ofs_ext;                                // [RULE_17]
      tick_cnt_q <= '0;
    end else if (tick) begin
      applied_q  <= applied_q + chunk_s[DFS_NUM_W-1:0];     // [RULE_16]
      remain_q   <= remain_q - chunk_s;
      tick_cnt_q <= '0;
    end else if (remain_q != '0) begin
      tick_cnt_q <= tick_cnt_q + 1'b1;
    end
  end

  // Set wins over the host clear in the same cycle
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ana_done <= 1'b0;
    end else if (finish || abs_set) begin
      ana_done <= 1'b1;                                     // [RULE_18]
    end else if (wr_ofs || (wr_stat && port.wdata[0])) begin
      ana_done <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ana_num_eff <= '0;
    end else begin
      ana_num_eff <= ana_base_q + applied_q;                // [RULE_14]
    end
  end

  // ----------------------------------------------------------------
  // Read-back, one cycle after the request
  // ----------------------------------------------------------------
  logic [DFS_NUM_W-1:0] rd_mux;
  always_comb begin
    case (port.addr)
      DFS_R_CTRL:     rd_mux = {34'h0, ctrl_q};
      DFS_R_DEV_STEP: rd_mux = step_ext;
      DFS_R_FB_NUM:   rd_mux = fb_num_q;
      DFS_R_FB_DEN:   rd_mux = fb_den_q;
      DFS_R_HOLD_OFS: rd_mux = hold_ofs_q;
      DFS_R_ANA_BASE: rd_mux = ana_base_q;
      DFS_R_STEP_SZ:  rd_mux = step_sz_q;
      DFS_R_STEP_PER: rd_mux = {24'h0, step_per_q};
      DFS_R_DIG_EFF:  rd_mux = dig_num_eff;
      DFS_R_ANA_EFF:  rd_mux = ana_num_eff;                 // [RULE_15]
      DFS_R_STATUS:   rd_mux = {39'h0, ana_done};
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rdata_q  <= '0;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= port.rd_en;
      if (port.rd_en) rdata_q <= rd_mux;
    end
  end
  assign port.rdata    = rdata_q;
  assign port.rd_valid = rvalid_q;

endmodule : dfs_device

// file: rtl/dfs_pkg.sv
package dfs_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int DFS_NUM_W  = 40;
  localparam int DFS_STEP_W = 38;
  localparam int DFS_ADR_W  = 4;
  localparam int DFS_PER_W  = 16;

  // ----------------------------------------------------------------
  // Device register indices on the control port
  // ----------------------------------------------------------------
  localparam logic [3:0] DFS_R_CTRL     = 4'h0;
  localparam logic [3:0] DFS_R_DEV_STEP = 4'h1;
  localparam logic [3:0] DFS_R_FB_NUM   = 4'h2;
  localparam logic [3:0] DFS_R_FB_DEN   = 4'h3;
  localparam logic [3:0] DFS_R_UPDATE   = 4'h4;
  localparam logic [3:0] DFS_R_HOLD_OFS = 4'h5;
  localparam logic [3:0] DFS_R_ANA_BASE = 4'h6;
  localparam logic [3:0] DFS_R_STEP_SZ  = 4'h7;
  localparam logic [3:0] DFS_R_STEP_PER = 4'h8;
  localparam logic [3:0] DFS_R_DIG_EFF  = 4'h9;
  localparam logic [3:0] DFS_R_ANA_EFF  = 4'hA;
  localparam logic [3:0] DFS_R_STATUS   = 4'hB;

  // Control register bit positions
  localparam int DFS_C_DEV_EN   = 0;
  localparam int DFS_C_HIST_EN  = 1;
  localparam int DFS_C_LOOP_EN  = 2;
  localparam int DFS_C_DEN_MODE = 3;
  localparam int DFS_C_DPLL_EN  = 4;
  localparam int DFS_C_PIN_EN   = 5;
  localparam int DFS_CTRL_W     = 6;
  localparam logic [5:0] DFS_CTRL_RST = 6'h00;

  // ----------------------------------------------------------------
  // Host AXI4-Lite byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] DFS_A_CMD_ADR = 8'h00;
  localparam logic [7:0] DFS_A_DATA_LO = 8'h04;
  localparam logic [7:0] DFS_A_DATA_HI = 8'h08;
  localparam logic [7:0] DFS_A_GO      = 8'h0C;
  localparam logic [7:0] DFS_A_STATUS  = 8'h10;
  localparam logic [7:0] DFS_A_RD_LO   = 8'h14;
  localparam logic [7:0] DFS_A_RD_HI   = 8'h18;
  localparam logic [7:0] DFS_A_PIN     = 8'h1C;
  localparam logic [1:0] DFS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DFS_RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Pin timing at core_clk
  // ----------------------------------------------------------------
  localparam int DFS_CLK_NS      = 20;
  localparam int DFS_TRIG_MIN_NS = 100;
  localparam int DFS_RATE_MAX_MHZ = 5;
  // Strictly longer than the minimum, so one cycle beyond the quotient
  localparam int DFS_TRIG_HI_CYC = DFS_TRIG_MIN_NS / DFS_CLK_NS + 1;
  localparam int DFS_EVT_PER_CYC =
    (1000 / DFS_RATE_MAX_MHZ) / DFS_CLK_NS + 1;
  localparam logic [7:0] DFS_PULSE_CNT = 8'(DFS_EVT_PER_CYC);
  localparam logic [7:0] DFS_PULSE_LOW =
    8'(DFS_EVT_PER_CYC - DFS_TRIG_HI_CYC);

endpackage : dfs_pkg

// file: rtl/dfs_if.sv
interface dfs_if;
  import dfs_pkg::*;
  logic                 wr_en;
  logic                 rd_en;
  logic [DFS_ADR_W-1:0] addr;
  logic [DFS_NUM_W-1:0] wdata;
  logic [DFS_NUM_W-1:0] rdata;
  logic                 rd_valid;
  logic                 step_trig;
  logic                 step_dir;

  modport dev  (input  wr_en, rd_en, addr, wdata, step_trig, step_dir,
                output rdata, rd_valid);
  modport host (output wr_en, rd_en, addr, wdata, step_trig, step_dir,
                input  rdata, rd_valid);
endinterface : dfs_if

// file: rtl/dfs_pin_sync.sv
module dfs_pin_sync #(
  parameter int W = 2
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] level,
  output logic      [W-1:0] rise
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;
  logic [W-1:0] last_q;

  // Edge detect reads only the second and third stages
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        meta_q[i] <= 1'b0;
        sync_q[i] <= 1'b0;
        last_q[i] <= 1'b0;
      end else begin
        meta_q[i] <= pin[i];
        sync_q[i] <= meta_q[i];
        last_q[i] <= sync_q[i];
      end
    end
    assign rise[i] = sync_q[i] & ~last_q[i];
  end
  assign level = sync_q;
endmodule : dfs_pin_sync

// file: rtl/dfs_host.sv
module dfs_host
  import dfs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  dfs_if.host              port,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  typedef enum logic [1:0] {DFS_H_IDLE, DFS_H_WAIT} dfs_hstate_t;

  // ----------------------------------------------------------------
  // AXI4-Lite write side
  // ----------------------------------------------------------------
  logic [7:0]  awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;
  logic [3:0]  adr_q;
  logic [39:0] data_q;
  logic [39:0] rd_q;
  logic        dir_q;
  logic        trig_q;
  logic [7:0]  pulse_cnt_q;
  logic        wr_en_q;
  logic        rd_en_q;
  dfs_hstate_t state_q;

  wire aw_hs   = s_axi_awvalid && s_axi_awready;
  wire w_hs    = s_axi_wvalid && s_axi_wready;
  wire do_wr   = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
  wire w_map   = awaddr_q[7:5] == 3'h0 && awaddr_q[1:0] == 2'h0;
  wire w_en    = do_wr && wstrb_q != 4'h0;
  wire w_adr   = w_en && awaddr_q == DFS_A_CMD_ADR;
  wire w_lo    = w_en && awaddr_q == DFS_A_DATA_LO;
  wire w_hi    = w_en && awaddr_q == DFS_A_DATA_HI;
  wire w_go    = w_en && awaddr_q == DFS_A_GO;
  wire w_pin   = w_en && awaddr_q == DFS_A_PIN;
  wire idle    = state_q == DFS_H_IDLE && !wr_en_q;
  wire go_wr   = w_go && wdata_q[0] && idle;
  wire go_rd   = w_go && wdata_q[1] && !wdata_q[0] && idle;
  wire pulse_r = w_pin && wdata_q[1] && pulse_cnt_q == 8'h00;

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= DFS_RESP_OKAY;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0;
      wstrb_q       <= 4'h0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        awaddr_q      <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
      end
      if (do_wr) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_map ? DFS_RESP_OKAY : DFS_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      adr_q <= 4'h0;
      data_q <= 40'h0;
      dir_q <= 1'b0;
    end else begin
      if (w_adr) adr_q <= wdata_q[3:0];
      if (w_lo)  data_q[31:0] <= wdata_q;
      if (w_hi)  data_q[39:32] <= wdata_q[7:0];
      if (w_pin) dir_q <= wdata_q[0];                       // [RULE_06]
    end
  end

  // ----------------------------------------------------------------
  // Command sequencer on the control port
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= DFS_H_IDLE;
      wr_en_q <= 1'b0;
      rd_en_q <= 1'b0;
      rd_q    <= 40'h0;
    end else begin
      wr_en_q <= go_wr;
      rd_en_q <= go_rd;
      case (state_q)
        DFS_H_IDLE: if (go_rd) state_q <= DFS_H_WAIT;
        DFS_H_WAIT: begin
          if (port.rd_valid) begin
            rd_q    <= port.rdata;
            state_q <= DFS_H_IDLE;
          end
        end
        default: state_q <= DFS_H_IDLE;
      endcase
    end
  end

  // Pulse is held high long enough to be sampled and spaced so the
  // event rate stays under the limit; requests during a pulse are
  // dropped, visible as the pulse-busy status bit.
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      trig_q      <= 1'b0;
      pulse_cnt_q <= 8'h00;
    end else if (pulse_r) begin
      trig_q      <= 1'b1;                                  // [RULE_07]
      pulse_cnt_q <= DFS_PULSE_CNT;                         // [RULE_08]
    end else if (pulse_cnt_q != 8'h00) begin
      pulse_cnt_q <= pulse_cnt_q - 8'h01;
      if (pulse_cnt_q == DFS_PULSE_LOW + 8'h01) trig_q <= 1'b0;
    end
  end

  assign port.wr_en     = wr_en_q;
  assign port.rd_en     = rd_en_q;
  assign port.addr      = adr_q;
  assign port.wdata     = data_q;
  assign port.step_trig = trig_q;
  assign port.step_dir  = dir_q;

  // ----------------------------------------------------------------
  // AXI4-Lite read side
  // ----------------------------------------------------------------
  logic [31:0] r_mux;
  wire r_map = s_axi_araddr[7:5] == 3'h0 && s_axi_araddr[1:0] == 2'h0;
  wire busy  = !idle;
  always_comb begin
    case (s_axi_araddr)
      DFS_A_CMD_ADR: r_mux = {28'h0, adr_q};
      DFS_A_DATA_LO: r_mux = data_q[31:0];
      DFS_A_DATA_HI: r_mux = {24'h0, data_q[39:32]};
      DFS_A_STATUS:  r_mux = {30'h0, pulse_cnt_q != 8'h00, busy};
      DFS_A_RD_LO:   r_mux = rd_q[31:0];
      DFS_A_RD_HI:   r_mux = {24'h0, rd_q[39:32]};
      DFS_A_PIN:     r_mux = {31'h0, dir_q};
      default:       r_mux = 32'h0;
    endcase
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= DFS_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= r_mux;
      s_axi_rresp   <= r_map ? DFS_RESP_OKAY : DFS_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : dfs_host

// file: verif/dfs_checker.sv
module dfs_checker
  import dfs_pkg::*;
(
  input wire logic                 core_clk,
  input wire logic                 rst,
  input wire logic                 wr_en,
  input wire logic                 rd_en,
  input wire logic [DFS_ADR_W-1:0] addr,
  input wire logic [DFS_NUM_W-1:0] wdata,
  input wire logic [DFS_NUM_W-1:0] rdata,
  input wire logic                 rd_valid,
  input wire logic                 step_trig,
  input wire logic                 step_dir
);
  // ----------------------------------------------------------------
  // Control port and pin timing
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  a_read_answer: assert property (rd_en |=> rd_valid)
    else $error("read answer missing");
  a_valid_cause: assert property (rd_valid |-> $past(rd_en))
    else $error("read answer without request");
  a_rdata_hold: assert property (!rd_valid |-> $stable(rdata))
    else $error("read data moved between answers");
  a_rd_single: assert property (rd_valid |=> !rd_valid)
    else $error("read answer longer than one cycle");
  a_wr_single: assert property (wr_en |=> !wr_en)
    else $error("write strobe longer than one cycle");
  // Six cycles high is 120 ns, above the capture minimum
  a_trig_width: assert property ($rose(step_trig) |->
    step_trig [*6] ##1 !step_trig)
    else $error("trigger pulse width wrong");
  // Five low cycles keep the event rate under the limit
  a_trig_rate: assert property ($fell(step_trig) |->
    !step_trig [*5])
    else $error("trigger events too close");
  a_dir_steady: assert property (step_trig |-> $stable(step_dir))
    else $error("direction moved during trigger");

  c_step_down: cover property ($rose(step_trig) && step_dir);
  c_step_up:   cover property ($rose(step_trig) && !step_dir);
  c_read:      cover property (rd_valid);
  c_update:    cover property (wr_en && addr == DFS_R_UPDATE);
endmodule : dfs_checker

// file: verif/test_dco_frequency_steering.sv
module test_dco_frequency_steering
  import dfs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [39:0] NUM = 40'h80_0000_0000;
  localparam logic [39:0] STP = 40'h20_0000_0001;
  localparam logic [39:0] BAS = 40'h10_0000_0000;
  logic        core_clk = 1'b0, rst = 1'b1, in_holdover = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, ana_done;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic [39:0] dig_num_eff, ana_num_eff, q;
  logic [40:0] dig_den_eff;
  int          error_cnt = 0, tests_run = 0;

  dfs_if bus ();
  dfs_device u_dfs_device (.port(bus), .*);
  dfs_host u_dfs_host (.port(bus), .*);
  dfs_checker u_dfs_checker (.core_clk(core_clk), .rst(rst),
    .wr_en(bus.wr_en), .rd_en(bus.rd_en), .addr(bus.addr),
    .wdata(bus.wdata), .rdata(bus.rdata), .rd_valid(bus.rd_valid),
    .step_trig(bus.step_trig), .step_dir(bus.step_dir));

  always #10 core_clk = ~core_clk;

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [40:0] seen, input logic [40:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  // Ready is looked at on the falling edge so that the flop update at
  // the rising edge can never race the decision to release
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    logic aw, w, b;
    int   n;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    n = 0;
    b = 1'b0;
    while (!b && n < 100) begin
      @(negedge core_clk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      b = s_axi_bvalid === 1'b1;
      r = s_axi_bresp;
      n++;
      @(posedge core_clk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!b) error_cnt++;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    logic ar, v;
    int   n;
    @(posedge core_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    n = 0;
    v = 1'b0;
    while (!v && n < 100) begin
      @(negedge core_clk);
      ar = s_axi_arvalid & s_axi_arready;
      v = s_axi_rvalid === 1'b1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      n++;
      @(posedge core_clk);
      if (ar) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!v) error_cnt++;
  endtask : axi_rd

  task automatic dev(input logic rd, input logic [3:0] i,
                     input logic [39:0] v, output logic [39:0] o);
    logic [31:0] d, h;
    int          n;
    axi_wr(DFS_A_DATA_LO, v[31:0], rs);
    axi_wr(DFS_A_DATA_HI, {24'h00_0000, v[39:32]}, rs);
    axi_wr(DFS_A_CMD_ADR, {28'h000_0000, i}, rs);
    axi_wr(DFS_A_GO, rd ? 32'h0000_0002 : 32'h0000_0001, rs);
    d = 32'h0000_0001;
    for (n = 0; n < 20 && d[0] !== 1'b0; n++) axi_rd(DFS_A_STATUS, d, rs);
    if (d[0] !== 1'b0) error_cnt++;
    axi_rd(DFS_A_RD_LO, d, rs);
    axi_rd(DFS_A_RD_HI, h, rs);
    check(rs, DFS_RESP_OKAY);
    o = {h[7:0], d};
    repeat (2) @(negedge core_clk);
  endtask : dev

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_digital();
    dev(0, DFS_R_CTRL, 40'h00_0000_0031, q);
    dev(0, DFS_R_DEV_STEP, STP, q);
    dev(0, DFS_R_FB_NUM, NUM, q);
    check(dig_num_eff, NUM);
    dev(0, DFS_R_UPDATE, 40'h00_0000_0000, q);
    check(dig_num_eff, NUM + STP);
    dev(0, DFS_R_UPDATE, 40'h00_0000_0001, q);
    dev(0, DFS_R_UPDATE, 40'h00_0000_0001, q);
    check(dig_num_eff, NUM - STP);
    axi_wr(DFS_A_PIN, 32'h0000_0001, rs);
    axi_wr(DFS_A_PIN, 32'h0000_0003, rs);
    repeat (20) @(negedge core_clk);
    check(dig_num_eff, NUM - STP - STP);
    axi_wr(DFS_A_PIN, 32'h0000_0000, rs);
    axi_wr(DFS_A_PIN, 32'h0000_0002, rs);
    repeat (20) @(negedge core_clk);
    check(dig_num_eff, NUM - STP);
    dev(1, DFS_R_DIG_EFF, 40'h00_0000_0000, q);
    check(q, NUM - STP);
    dev(0, DFS_R_CTRL, 40'h00_0000_0030, q);
    check(dig_num_eff, NUM);
    dev(0, DFS_R_FB_DEN, 40'h00_0000_0005, q);
    check(dig_den_eff, 41'h000_0000_0005);
    dev(0, DFS_R_FB_DEN, 40'h00_0000_0000, q);
    check(dig_den_eff, 41'h100_0000_0000);
    axi_wr(8'h20, 32'h0000_0001, rs);
    check(rs, DFS_RESP_SLVERR);
    $display("t_digital done");
  endtask : t_digital

  task automatic t_analog();
    int n;
    @(posedge core_clk);
    in_holdover <= 1'b1;
    dev(0, DFS_R_CTRL, 40'h00_0000_000D, q);
    dev(0, DFS_R_ANA_BASE, BAS, q);
    dev(0, DFS_R_HOLD_OFS, 40'hFF_FFFF_FF00, q);
    dev(0, DFS_R_UPDATE, 40'h00_0000_0000, q);
    check(dig_num_eff, NUM);
    check(ana_num_eff, BAS - 40'd256);
    check(ana_done, 1'b1);
    dev(0, DFS_R_ANA_EFF, 40'h00_0000_0000, q);
    dev(1, DFS_R_ANA_EFF, 40'h00_0000_0000, q);
    check(q, BAS - 40'd256);
    dev(0, DFS_R_CTRL, 40'h00_0000_000F, q);
    dev(0, DFS_R_STEP_PER, 40'h00_0000_0002, q);
    dev(0, DFS_R_STEP_SZ, 40'h00_0000_0000, q);
    // A zero step size stalls the feed, so the drop is seen exactly
    dev(0, DFS_R_HOLD_OFS, 40'h00_0000_03E8, q);
    check(ana_done, 1'b0);
    check(ana_num_eff, BAS - 40'd256);
    dev(0, DFS_R_HOLD_OFS, 40'h00_0000_000C, q);
    dev(0, DFS_R_STEP_SZ, 40'h00_0000_0004, q);
    for (n = 0; n < 200 && ana_done !== 1'b1; n++) @(negedge core_clk);
    check(ana_num_eff, BAS - 40'd244);
    check(ana_done, 1'b1);
    $display("t_analog done");
  endtask : t_analog

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (20000) @(posedge core_clk);
    error_cnt++;
    tally_and_finish();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_digital();
    t_analog();
    tally_and_finish();
  end
endmodule : test_dco_frequency_steering
